// ### hw/cicr_router.sv
// camera input channel router: selector and rate/route checker
// assumes route and bytes-per-pixel inputs come from logic on i_clk_sys
module cicr_router #(
    parameter cicr_pkg::cicr_cfg_t CFG = cicr_pkg::CICR_CFG_OCT  // device configuration
) (
    input  wire logic                                              i_clk_sys,  // system clock
    input  wire logic                                              i_rst,      // async reset
    input  wire logic        [cicr_pkg::NUM_SRC-1:0]               i_pix_clk,  // link clocks
    input  wire cicr_pkg::cicr_route_t [cicr_pkg::NUM_CAP-1:0]     i_route,    // selector
    input  wire logic        [cicr_pkg::NUM_SRC-1:0][2:0]          i_src_bpp,  // bytes/pixel
    output logic             [cicr_pkg::NUM_CAP-1:0][cicr_pkg::SRC_W-1:0] o_cap_sel, // source
    output logic             [cicr_pkg::NUM_CAP-1:0]               o_cap_en,   // forwarding
    output cicr_pkg::cicr_err_t                                    o_err,      // error flags
    output logic                                                   o_cfg_err,  // any error
    output logic                                                   o_meas_valid // rates seen
);
    import cicr_pkg::*;

    typedef struct packed {
        logic [15:0]                       win_cnt;
        logic                              tick;
        logic                              chk;
        logic                              meas_valid;
        logic [NUM_CAP-1:0][SRC_W-1:0]     sel;
        logic [NUM_CAP-1:0]                en;
        cicr_err_t                         err;
        logic                              cfg_err;
    } cicr_rtr_state_t;

    cicr_rtr_state_t                st;
    cicr_rtr_state_t                next_st;
    logic [NUM_SRC-1:0][EDGE_W-1:0] edges;
    logic [NUM_CAP-1:0][31:0]       ch_clk;
    logic [NUM_CAP-1:0][31:0]       ch_in;
    logic [NUM_CAP-1:0][31:0]       ch_out;
    logic [31:0]                    sum_out;
    logic [31:0]                    quad_in;
    logic [31:0]                    dual_in;
    logic                           quad_used;
    logic                           dual_used;
    logic                           route_bad;
    logic                           vc0_bad;
    logic [1:0]                     p;

    // ==========================================================
    // link clock meters
    for (genvar s = 0; s < NUM_SRC; s++) begin : g_meter
        cicr_edge_meter u_meter (
            .i_clk_sys  (i_clk_sys),
            .i_rst      (i_rst),
            .i_link_clk (i_pix_clk[s]),
            .i_tick     (st.tick),
            .o_edges    (edges[s])
        );
    end

    // ==========================================================
    // selector and checks
    always_comb begin
        next_st   = st;
        route_bad = 1'b0;
        vc0_bad   = 1'b0;
        sum_out   = '0;
        quad_used = 1'b0;
        dual_used = 1'b0;
        p         = PHYS_PAR0;
        next_st.tick = 1'b0;
        next_st.chk  = st.tick;
        if (st.win_cnt == 16'(WIN_CYC - 1)) begin
            next_st.win_cnt = '0;
            next_st.tick    = 1'b1;
        end else begin
            next_st.win_cnt = st.win_cnt + 16'h0001;
        end

        for (int i = 0; i < NUM_CAP; i++) begin
            next_st.en[i]  = 1'b0;
            next_st.sel[i] = SRC_NONE;
            if (CFG == CICR_CFG_UNO) begin
                // no selector: channel 0 is hard-wired to the parallel port
                next_st.en[i]  = (i == 0);
                next_st.sel[i] = (i == 0) ? SRC_PAR0 : SRC_NONE;
            end else if (i_route[i].en && i_route[i].src != SRC_NONE) begin
                if (cicr_legal(CFG, i, i_route[i].src)) begin
                    // legal routes forward any of the four vcs
                    next_st.en[i]  = 1'b1;
                    next_st.sel[i] = i_route[i].src;
                end else begin
                    // illegal routes are blocked, not forwarded
                    route_bad = 1'b1;
                end
                vc0_bad = vc0_bad | cicr_vc0_bad(CFG, i, i_route[i].src);
            end
        end
        next_st.err.route = route_bad;
        next_st.err.vc0   = vc0_bad;

        // rates from the currently forwarded routes and last window's edges
        for (int i = 0; i < NUM_CAP; i++) begin
            p         = cicr_phys(st.sel[i]);
            ch_clk[i] = st.en[i] ? 32'(edges[p]) : 32'h0;
            ch_in[i]  = ch_clk[i] * 32'(i_src_bpp[p]);
            ch_out[i] = ch_clk[i] * 32'(i_route[i].scale) * 32'(i_route[i].depth);
            sum_out   = sum_out + ch_out[i];
            quad_used = quad_used | (st.en[i] & cicr_is_quad(st.sel[i]));
            dual_used = dual_used | (st.en[i] & cicr_is_dual(st.sel[i]));
        end
        quad_in = 32'(edges[PHYS_QUAD]) * 32'(i_src_bpp[PHYS_QUAD]);
        dual_in = 32'(edges[PHYS_DUAL]) * 32'(i_src_bpp[PHYS_DUAL]);

        if (st.chk) begin
            next_st.meas_valid   = 1'b1;
            next_st.err.clk      = 1'b0;
            next_st.err.out_rate = 1'b0;
            next_st.err.order    = 1'b0;
            for (int i = 0; i < NUM_CAP; i++) begin
                if (ch_clk[i] > cicr_ch_clk_lim(CFG))
                    next_st.err.clk = 1'b1;
                if (st.en[i] && cicr_phys(st.sel[i]) >= PHYS_PAR0
                        && ch_clk[i] > cicr_win(LIM_PAR_CLK))
                    next_st.err.clk = 1'b1;
                if (ch_out[i] > cicr_ch_out_lim(CFG))
                    next_st.err.out_rate = 1'b1;
                // the large-buffer channel of each group must carry its fastest stream
                if (st.en[i] && i != 0 && i != 4 && ch_in[i] > ch_in[(i >= 4) ? 4 : 0])
                    next_st.err.order = 1'b1;
            end
            next_st.err.sum_rate = sum_out > cicr_sum_lim(CFG);
            next_st.err.in_rate  = 1'b0;
            if (CFG == CICR_CFG_OCT) begin
                next_st.err.in_rate =
                    (quad_used && quad_in > cicr_win(LIM_QUAD_IN_OCT)) ||
                    (dual_used && dual_in > cicr_win(LIM_DUAL_IN_OCT)) ||
                    (quad_used && quad_in > cicr_win(LIM_LANE * LANES_QUAD_OCT)) ||
                    (dual_used && dual_in > cicr_win(LIM_LANE * LANES_DUAL));
            end else if (CFG == CICR_CFG_DUO) begin
                // four-lane receiver but only two lanes bonded out
                next_st.err.in_rate =
                    (quad_used && quad_in > cicr_win(LIM_QUAD_IN_DUO)) ||
                    (quad_used && quad_in > cicr_win(LIM_LANE * LANES_QUAD_DUO));
            end
        end
        next_st.cfg_err = |next_st.err;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_cap_sel    = st.sel;
    assign o_cap_en     = st.en;
    assign o_err        = st.err;
    assign o_cfg_err    = st.cfg_err;
    assign o_meas_valid = st.meas_valid;

    // ==========================================================
    // assertions
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    cap_count_a: assert property (CFG == CICR_CFG_DUO |-> (o_cap_en & 8'hcf) == 8'h00)
        else $error("channel outside 4/5 enabled in two-channel config");

    uno_par_a: assert property ($past(!i_rst) && CFG == CICR_CFG_UNO |->
                                o_cap_en == 8'h01 && o_cap_sel[0] == SRC_PAR0)
        else $error("single-channel config not fed from parallel port");

    vc_forward_a: assert property (CFG != CICR_CFG_UNO && i_route[1].en
                                   && i_route[1].src != SRC_NONE
                                   && cicr_legal(CFG, 1, i_route[1].src)
                                   |=> o_cap_en[1] && o_cap_sel[1] == $past(i_route[1].src))
        else $error("legal route not forwarded");

    in_rate_a: assert property (st.chk && CFG == CICR_CFG_DUO && quad_used
                                && quad_in > cicr_win(LIM_QUAD_IN_DUO) |=> o_err.in_rate)
        else $error("receiver over-rate not flagged");

    big_buf_a: assert property (st.chk && st.en[5] && ch_in[5] > ch_in[4]
                                |=> o_err.order && o_cfg_err)
        else $error("faster stream off large-buffer channel not flagged");

    bad_route_a: assert property (CFG == CICR_CFG_OCT && i_route[4].en
                                  && i_route[4].src == SRC_QUAD_VC0
                                  |=> o_cfg_err && o_err.route && !o_cap_en[4])
        else $error("illegal route forwarded or not flagged");

    rate_hold_a: assert property (!st.chk |=> $stable(o_err.out_rate))
        else $error("rate flag changed outside a check");

    sum_rate_a: assert property (st.chk && sum_out > cicr_sum_lim(CFG)
                                 |=> o_err.sum_rate ##[1:600] $rose(st.chk))
        else $error("sum over-rate not flagged");

    route_err_c: cover property (o_err.route);
    order_err_c: cover property (o_err.order);
    meas_c:      cover property ($rose(o_meas_valid));
    rate_ok_c:   cover property (o_meas_valid && !o_cfg_err && |o_cap_en);

endmodule

// ### include/cicr_pkg.sv
// camera input channel router: shared constants, types and limit functions
// assumes a 50 MHz system clock; limits are held in hundredths of MHz or Mbyte/s
package cicr_pkg;

    // ==========================================================
    // configurations and sizes
    typedef enum logic [2:0] {
        CICR_CFG_OCT = 3'b001,   // quad + dual receiver, eight capture channels
        CICR_CFG_DUO = 3'b010,   // one receiver with two usable lanes, two channels
        CICR_CFG_UNO = 3'b100    // parallel port only, one channel
    } cicr_cfg_t;

    localparam int NUM_CAP = 8;
    localparam int NUM_SRC = 4;
    localparam int SRC_W   = 4;
    localparam int EDGE_W  = 16;

    // physical source index
    localparam logic [1:0] PHYS_QUAD = 2'h0;
    localparam logic [1:0] PHYS_DUAL = 2'h1;
    localparam logic [1:0] PHYS_PAR0 = 2'h2;
    localparam logic [1:0] PHYS_PAR1 = 2'h3;

    // selector codes
    localparam logic [SRC_W-1:0] SRC_NONE     = 4'h0;
    localparam logic [SRC_W-1:0] SRC_QUAD_VC0 = 4'h1;  // quad vc 0..3 = 1..4
    localparam logic [SRC_W-1:0] SRC_QUAD_VC3 = 4'h4;
    localparam logic [SRC_W-1:0] SRC_DUAL_VC0 = 4'h5;  // dual vc 0..3 = 5..8
    localparam logic [SRC_W-1:0] SRC_DUAL_VC3 = 4'h8;
    localparam logic [SRC_W-1:0] SRC_PAR0     = 4'h9;
    localparam logic [SRC_W-1:0] SRC_PAR1     = 4'ha;

    // ==========================================================
    // timing
    localparam int CLK_MHZ   = 50;
    localparam int WINDOW_US = 10;
    localparam int WIN_CYC   = CLK_MHZ * WINDOW_US;

    // ==========================================================
    // limits, x100 (MHz or Mbyte/s)
    localparam int LIM_QUAD_IN_OCT = 44550;
    localparam int LIM_DUAL_IN_OCT = 22275;
    localparam int LIM_QUAD_IN_DUO = 22275;
    localparam int LIM_PAR_CLK     = 10000;
    localparam int LIM_CH_CLK_OCT  = 14850;
    localparam int LIM_CH_CLK_LOW  = 7425;
    localparam int LIM_CH_OUT_OCT  = 59400;
    localparam int LIM_SUM_OCT     = 89100;
    localparam int LIM_CH_OUT_DUO  = 29700;
    localparam int LIM_SUM_DUO     = 44550;
    localparam int LIM_CH_OUT_UNO  = 14850;
    localparam int LIM_LANE        = 18750;   // 1.5 Gbit/s per lane
    localparam int LANES_QUAD_OCT  = 4;
    localparam int LANES_QUAD_DUO  = 2;
    localparam int LANES_DUAL      = 2;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic             en;
        logic [SRC_W-1:0] src;
        logic [1:0]       scale;
        logic [2:0]       depth;
    } cicr_route_t;

    typedef struct packed {
        logic route;
        logic vc0;
        logic clk;
        logic in_rate;
        logic out_rate;
        logic sum_rate;
        logic order;
    } cicr_err_t;

    // ==========================================================
    // functions
    function automatic logic [31:0] cicr_win(input int x100);
        return 32'(x100 * WINDOW_US / 100);
    endfunction

    function automatic logic cicr_is_quad(input logic [SRC_W-1:0] s);
        return (s >= SRC_QUAD_VC0) && (s <= SRC_QUAD_VC3);
    endfunction

    function automatic logic cicr_is_dual(input logic [SRC_W-1:0] s);
        return (s >= SRC_DUAL_VC0) && (s <= SRC_DUAL_VC3);
    endfunction

    function automatic logic [1:0] cicr_phys(input logic [SRC_W-1:0] s);
        if (cicr_is_quad(s)) return PHYS_QUAD;
        if (cicr_is_dual(s)) return PHYS_DUAL;
        if (s == SRC_PAR1) return PHYS_PAR1;
        return PHYS_PAR0;
    endfunction

    // may this source reach this capture channel at all
    function automatic logic cicr_legal(input cicr_cfg_t c, input int ch,
                                        input logic [SRC_W-1:0] s);
        logic par;
        par = (s == SRC_PAR0) || (s == SRC_PAR1);
        case (c)
            CICR_CFG_OCT: return (cicr_is_quad(s) && ch < 4) || (cicr_is_dual(s) && ch >= 4)
                                 || (par && (ch == 4 || ch == 5));
            CICR_CFG_DUO: return (cicr_is_quad(s) || par) && (ch == 4 || ch == 5);
            default:      return (s == SRC_PAR0) && ch == 0;
        endcase
    endfunction

    // vc0 of a receiver landed somewhere other than its large-buffer channel
    function automatic logic cicr_vc0_bad(input cicr_cfg_t c, input int ch,
                                          input logic [SRC_W-1:0] s);
        if (s == SRC_QUAD_VC0) return ch != ((c == CICR_CFG_OCT) ? 0 : 4);
        if (s == SRC_DUAL_VC0) return ch != 4;
        return 1'b0;
    endfunction

    function automatic logic [31:0] cicr_ch_clk_lim(input cicr_cfg_t c);
        return cicr_win((c == CICR_CFG_OCT) ? LIM_CH_CLK_OCT : LIM_CH_CLK_LOW);
    endfunction

    function automatic logic [31:0] cicr_ch_out_lim(input cicr_cfg_t c);
        case (c)
            CICR_CFG_OCT: return cicr_win(LIM_CH_OUT_OCT);
            CICR_CFG_DUO: return cicr_win(LIM_CH_OUT_DUO);
            default:      return cicr_win(LIM_CH_OUT_UNO);
        endcase
    endfunction

    function automatic logic [31:0] cicr_sum_lim(input cicr_cfg_t c);
        case (c)
            CICR_CFG_OCT: return cicr_win(LIM_SUM_OCT);
            CICR_CFG_DUO: return cicr_win(LIM_SUM_DUO);
            default:      return cicr_win(LIM_CH_OUT_UNO);
        endcase
    endfunction

endpackage

// ### hw/cicr_edge_meter.sv
// camera input channel router: link clock edge meter
// assumes i_tick is a one-cycle pulse once per measurement window
module cicr_edge_meter (
    input  wire logic                        i_clk_sys,   // system clock
    input  wire logic                        i_rst,       // async reset, high
    input  wire logic                        i_link_clk,  // pixel clock pin
    input  wire logic                        i_tick,      // window end
    output logic      [cicr_pkg::EDGE_W-1:0] o_edges      // edges last window
);
    import cicr_pkg::*;

    typedef struct packed {
        logic [1:0]        sync;
        logic              prev;
        logic [EDGE_W-1:0] cnt;
        logic [EDGE_W-1:0] edges;
    } cicr_mtr_state_t;

    cicr_mtr_state_t st;
    cicr_mtr_state_t next_st;
    logic            rise;

    // ==========================================================
    // edge counting
    always_comb begin
        next_st = st;
        // sync[0] feeds only sync[1]
        next_st.sync = {st.sync[0], i_link_clk};
        next_st.prev = st.sync[1];
        rise = st.sync[1] & ~st.prev;
        if (i_tick) begin
            next_st.edges = st.cnt + EDGE_W'(rise);
            next_st.cnt   = '0;
        end else if (rise && st.cnt != '1) begin
            // saturate rather than wrap so a runaway clock still reads as too fast
            next_st.cnt = st.cnt + EDGE_W'(1);
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_edges = st.edges;

endmodule

// ### verification/cicr_src_model.sv
// camera input channel router: model of the camera or parallel video sources
// assumes the bench picks which sources stream and at which of two pixel rates
module cicr_src_model (
    input  wire logic [3:0] i_run,      // source streaming
    input  wire logic [3:0] i_fast,     // 80 ns pixel clock instead of 160 ns
    output logic      [3:0] o_pix_clk   // pixel clocks toward the router
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // pixel clocks
    // rates stay far below lane, receiver and port limits
    // all streams of one receiver share its clock, vc zero included
    logic clk_q [4];

    for (genvar g = 0; g < 4; g++) begin : gen_src
        initial begin
            clk_q[g] = 1'b0;
            // offsets of 3, 16, 29 and 42 ns keep the sources out of phase with the system clock
            #(13 * g + 3);
            forever begin
                if (i_run[g]) begin
                    #(i_fast[g] ? 40 : 80);
                    clk_q[g] = ~clk_q[g];
                end else begin
                    // stands still low between frames
                    clk_q[g] = 1'b0;
                    #5;
                end
            end
        end
    end

    assign o_pix_clk = {clk_q[3], clk_q[2], clk_q[1], clk_q[0]};
endmodule

// ### verification/cicr_tb.sv
// camera input channel router: self-checking bench, all three configurations side by side
// assumes the source model drives the four pixel clocks
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import cicr_pkg::*;

    typedef struct packed {
        logic [1:0]                    cfg;
        logic [NUM_CAP-1:0]            en;
        logic [NUM_CAP-1:0][SRC_W-1:0] sel;
        logic                          rt;
        logic                          vc;
        logic                          vm;   // vc0 flag defined
    } cicr_sel_note_t;

    typedef struct packed {
        logic [1:0] cfg;
        logic [4:0] bits;  // clk, in, out, sum, order
        logic       rt;    // route flag standing meanwhile
        logic       mv;
    } cicr_rate_note_t;

    localparam cicr_cfg_t CFGS [3] = '{CICR_CFG_OCT, CICR_CFG_DUO, CICR_CFG_UNO};

    logic                          i_clk_sys = 1'b0;
    logic                          i_rst     = 1'b1;
    logic [NUM_SRC-1:0]            pix_clk;
    logic [NUM_SRC-1:0]            run       = 4'hf;
    logic [NUM_SRC-1:0]            fast      = 4'h0;
    cicr_route_t [NUM_CAP-1:0]     route     = '0;
    logic [NUM_SRC-1:0][2:0]       bpp       = '0;
    logic [NUM_CAP-1:0][SRC_W-1:0] cap_sel [3];
    logic [NUM_CAP-1:0]            cap_en [3];
    cicr_err_t                     err [3];
    logic                          cfg_err [3];
    logic                          mv [3];
    cicr_sel_note_t                q_sel [$];
    cicr_rate_note_t               q_rate [$];
    int                            n_mismatch = 0;
    int                            num_checks = 0;
    logic [31:0]                   seed       = 32'h0000_0060;

    for (genvar g = 0; g < 3; g++) begin : gen_cfg
        cicr_router #(.CFG(CFGS[g])) dut_u (
            .i_clk_sys    (i_clk_sys),
            .i_rst        (i_rst),
            .i_pix_clk    (pix_clk),
            .i_route      (route),
            .i_src_bpp    (bpp),
            .o_cap_sel    (cap_sel[g]),
            .o_cap_en     (cap_en[g]),
            .o_err        (err[g]),
            .o_cfg_err    (cfg_err[g]),
            .o_meas_valid (mv[g])
        );
    end

    cicr_src_model src_u (.i_run(run), .i_fast(fast), .o_pix_clk(pix_clk));

    always #10 i_clk_sys = ~i_clk_sys;

    // ==========================================================
    // reference
    function automatic logic [31:0] xs_next(input logic [31:0] s);
        logic [31:0] v;
        v = s ^ (s << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction

    function automatic logic src_ok(input int c, input int ch, input logic [3:0] s);
        logic q;
        logic d;
        logic p;
        q = (s >= 4'h1) && (s <= 4'h4);
        d = (s >= 4'h5) && (s <= 4'h8);
        p = (s == 4'h9) || (s == 4'ha);
        if (c == 0) begin
            return (q && ch < 4) || (d && ch >= 4) || (p && (ch == 4 || ch == 5));
        end
        return (q || p) && (ch == 4 || ch == 5);
    endfunction

    function automatic cicr_sel_note_t expect_sel(input int c, input cicr_route_t [NUM_CAP-1:0] r);
        cicr_sel_note_t n;
        int             home;
        logic           z;
        n = '0;
        n.cfg = 2'(c);
        n.vm = 1'b1;
        for (int ch = 0; ch < NUM_CAP; ch++) begin
            home = (r[ch].src == 4'h1 && c == 0) ? 0 : 4;
            z = (r[ch].src == 4'h1) || (r[ch].src == 4'h5);
            if (c == 2 || !r[ch].en || r[ch].src == 4'h0) begin
                continue;
            end
            // vc0 away from its home is flagged, legal route or not
            n.vc = n.vc | (z && ch != home);
            if (src_ok(c, ch, r[ch].src)) begin
                n.en[ch] = 1'b1;
                n.sel[ch] = r[ch].src;
            end else begin
                n.rt = 1'b1;
            end
        end
        if (c == 2) begin
            n.en = 8'h01;
            n.sel[0] = 4'h9;
        end
        return n;
    endfunction

    // ==========================================================
    // comparison and verdict
    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_sel(input cicr_sel_note_t n);
        cmp(64'(cap_en[n.cfg]), 64'(n.en));
        cmp(64'(cap_sel[n.cfg]), 64'(n.sel));
        if (n.cfg != 2'd2) begin
            cmp(64'(err[n.cfg].route), 64'(n.rt));
            if (n.vm) begin
                cmp(64'(err[n.cfg].vc0), 64'(n.vc));
            end
        end
    endtask

    task automatic chk_rate(input cicr_rate_note_t n);
        cmp(64'({err[n.cfg].clk, err[n.cfg].in_rate, err[n.cfg].out_rate,
                 err[n.cfg].sum_rate, err[n.cfg].order}), 64'(n.bits));
        cmp(64'(err[n.cfg].route), 64'(n.rt));
        cmp(64'(cfg_err[n.cfg]), 64'(|n.bits | n.rt));
        cmp(64'(mv[n.cfg]), 64'(n.mv));
    endtask

    task automatic final_report();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge i_clk_sys) begin
        #1;
        while (q_sel.size() > 0) begin
            chk_sel(q_sel.pop_front());
        end
        while (q_rate.size() > 0) begin
            chk_rate(q_rate.pop_front());
        end
    end

    // ==========================================================
    // drivers
    task automatic apply(input cicr_route_t [NUM_CAP-1:0] r);
        @(negedge i_clk_sys);
        route = r;
        for (int c = 0; c < 3; c++) begin
            q_sel.push_back(expect_sel(c, r));
        end
    endtask

    // a full steady window must pass before the flags are judged
    task automatic rate_case(input logic [3:0] r_run, input logic [3:0] r_fast,
                             input logic [4:0] oct_bits, input logic [4:0] duo_bits,
                             input logic duo_rt, input logic [4:0] uno_bits);
        @(negedge i_clk_sys);
        run = r_run;
        fast = r_fast;
        repeat (2 * WIN_CYC + 5) @(negedge i_clk_sys);
        q_rate.push_back(cicr_rate_note_t'{2'd0, oct_bits, 1'b0, 1'b1});
        q_rate.push_back(cicr_rate_note_t'{2'd1, duo_bits, duo_rt, 1'b1});
        q_rate.push_back(cicr_rate_note_t'{2'd2, uno_bits, 1'b0, 1'b1});
    endtask

    initial begin
        repeat (6000) @(posedge i_clk_sys);
        n_mismatch++;
        final_report();
    end

    initial begin
        cicr_route_t [NUM_CAP-1:0] r;
        repeat (16) @(negedge i_clk_sys);
        for (int c = 0; c < 3; c++) begin
            cmp(64'({cap_en[c], cap_sel[c], err[c], cfg_err[c], mv[c]}), 64'h0);
        end
        i_rst = 1'b0;
        apply('0);
        for (int ch = 0; ch < NUM_CAP; ch++) begin
            for (int s = 1; s <= 10; s++) begin
                r = '0;
                r[ch] = cicr_route_t'{1'b1, 4'(s), 2'h1, 3'h1};
                apply(r);
            end
        end
        repeat (60) begin
            for (int ch = 0; ch < NUM_CAP; ch++) begin
                seed = xs_next(seed);
                r[ch] = cicr_route_t'{seed[0], 4'(1 + seed[11:4] % 10), seed[13:12], seed[16:14]};
                bpp[ch % NUM_SRC] = 3'(1 + seed[18:17]);
            end
            apply(r);
        end
        apply('0);
        @(negedge i_clk_sys);
        q_rate.push_back(cicr_rate_note_t'{2'd0, 5'h00, 1'b0, 1'b0});
        bpp = {4{3'h1}};
        r = '0;
        for (int ch = 0; ch < 4; ch++) begin
            r[ch] = cicr_route_t'{1'b1, 4'(ch + 1), 2'h3, 3'h7};
        end
        apply(r);
        // four fast quad channels: each under its limit, the sum over it
        // two-channel config refuses all four routes and sees no rate
        rate_case(4'b0001, 4'b0001, 5'b00010, 5'b00000, 1'b1, 5'b00000);
        r = '0;
        r[0] = cicr_route_t'{1'b0, 4'h0, 2'h3, 3'h7};
        r[4] = cicr_route_t'{1'b1, 4'h5, 2'h1, 3'h1};
        r[5] = cicr_route_t'{1'b1, 4'h9, 2'h1, 3'h1};
        apply(r);
        // two-channel config: dual refused, parallel on ch5 outruns empty ch4
        rate_case(4'b0110, 4'b0100, 5'b00001, 5'b00001, 1'b1, 5'b00110);
        rate_case(4'b0110, 4'b0010, 5'b00000, 5'b00001, 1'b1, 5'b00000);
        repeat (3) @(posedge i_clk_sys);
        final_report();
    end
endmodule
